/* core/cosp_clkdiv.sv */
`timescale 1ns/100ps
`default_nettype none
module cosp_clkdiv
  import cosp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic [3:0] divider,
  // divided pll clock
  output logic clk_div
);
  cosp_div_st_t q, d;
  logic [32:0] sum;

  always_comb begin
    d = q;
    sum = {1'b0, q.acc} + {1'b0, NCO_INC};
    d.acc = sum[31:0];
    if (!run) begin
      d.cnt = 4'h0;
      d.clk = 1'b0;
    end else if (sum[32]) begin
      // one pll half period per carry, so toggling every divider+1 carries
      if (q.cnt == divider) begin
        d.cnt = 4'h0;
        d.clk = ~q.clk;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_div = q.clk;
endmodule : cosp_clkdiv
`default_nettype wire

/* core/cosp_ctrl.sv */
// How it works
// - pll multiplies 6 MHz reference to 48 MHz
// - clock_output programmable from 3 to 48 MHz
// - four-bit clock_output_divider sets the division factor
// - osc_run switches the crystal oscillator on/off
// - suspend powers down oscillator and pll
// - suspend uses 100 kHz low-rate clock unless disabled
// - suspend_request set-then-clear enters suspend after 2 ms
// - wake pulse leaves suspend after 0.5 ms
// - supply dip beyond 11 us asserts internal reset
// - reset starts asserted, held pulse width after recovery
// - reset pulse width at least 600 ns; a pin reset is not stretched and lasts as long as reset_pin_n is held low
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cosp_ctrl
  import cosp_pkg::*;
#(
  parameter int SUSP_CYCLES = SUSP_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register bus
  input wire cosp_axi_req_t axi_req,
  output cosp_axi_rsp_t axi_rsp,
  // pins
  input wire logic osc_ref_in,
  input wire logic device_wake_in,
  input wire logic vmon_ok,
  input wire logic reset_pin_n,
  // outputs
  output logic osc_enable,
  output logic pll_enable,
  output logic clock_output,
  output logic device_suspend_out,
  output logic int_reset
);
  cosp_st_t q, d;
  logic int_rst;
  logic clk_div;
  logic osc_on;
  logic wr_fire;
  logic susp_fall;
  logic wake_rise;
  logic ref_rise;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;

  function automatic logic [31:0] reg_read(input logic [AW-1:0] a, input cosp_st_t s, output logic err);
    logic [31:0] v;
    v = 32'h0;
    err = 1'b0;
    case (a)
      HW_CONFIG_OFS: begin
        v[HW_DIV_LSB +: 4] = s.div;
        v[HW_OSC_RUN_BIT] = s.osc_run;
        v[HW_SLOW_DIS_BIT] = s.slow_dis;
      end
      MODE_OFS: begin
        v[MODE_SUSP_REQ_BIT] = s.susp_req;
      end
      STATUS_OFS: begin
        v[ST_SUSPENDED_BIT] = (s.pwr == ST_SUSPENDED);
        v[ST_WAKE_WAIT_BIT] = (s.pwr == ST_WAKE_WAIT);
        v[ST_PLL_LOCK_BIT] = s.locked;
        v[ST_LOW_RATE_BIT] = (s.pwr == ST_SUSPENDED) && !s.slow_dis;
        v[ST_SUSP_WAIT_BIT] = (s.pwr == ST_SUSP_WAIT);
        v[ST_OSC_ON_BIT] = s.osc_run && (s.pwr != ST_SUSPENDED);
      end
      default: begin
        err = 1'b1;
      end
    endcase
    return v;
  endfunction : reg_read

  // internal reset: monitor or pin
  assign int_rst = q.por || !q.rstp_s2;
  // oscillator and pll off in suspend
  assign osc_on = q.osc_run && (q.pwr != ST_SUSPENDED);

  cosp_clkdiv u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(osc_on && q.locked),
    .divider(q.div),
    .clk_div(clk_div)
  );

  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign ref_rise = q.osc_s2 && !q.osc_s3;
  assign wake_rise = q.wake_s2 && !q.wake_s3;

  always_comb begin
    d = q;
    susp_fall = 1'b0;
    rd_resp = RESP_OKAY;
    rd_val = 32'h0;
    // synchronisers
    d.osc_s1 = osc_ref_in;
    d.osc_s2 = q.osc_s1;
    d.osc_s3 = q.osc_s2;
    d.wake_s1 = device_wake_in;
    d.wake_s2 = q.wake_s1;
    d.wake_s3 = q.wake_s2;
    d.vmon_s1 = vmon_ok;
    d.vmon_s2 = q.vmon_s1;
    d.rstp_s1 = reset_pin_n;
    d.rstp_s2 = q.rstp_s1;

    // supply monitor: long dip sets, recovery plus pulse width clears
    if (!q.vmon_s2) begin
      d.hold_cnt = 8'h0;
      if (q.low_cnt >= 12'(POR_DIP_CYC)) begin
        d.por = 1'b1;
      end else begin
        d.low_cnt = q.low_cnt + 12'h1;
      end
    end else begin
      d.low_cnt = 12'h0;
      if (q.por) begin
        if (q.hold_cnt >= 8'(POR_PULSE_CYC - 1)) begin
          d.por = 1'b0;
        end else begin
          d.hold_cnt = q.hold_cnt + 8'h1;
        end
      end
    end

    // pll lock tracking on reference edges
    if (!osc_on) begin
      d.lock_cnt = 5'h0;
      d.locked = 1'b0;
      d.loss_cnt = 7'h0;
    end else if (ref_rise) begin
      d.loss_cnt = 7'h0;
      if (q.lock_cnt >= 5'(PLL_LOCK_EDGES - 1)) begin
        d.locked = 1'b1;
      end else begin
        d.lock_cnt = q.lock_cnt + 5'h1;
      end
    end else if (q.loss_cnt >= 7'(REF_LOSS_CYC - 1)) begin
      d.lock_cnt = 5'h0;
      d.locked = 1'b0;
    end else begin
      d.loss_cnt = q.loss_cnt + 7'h1;
    end

    // write channel
    if (axi_req.awvalid && axi_rsp.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.awaddr)
        HW_CONFIG_OFS: begin
          if (q.wstrb[0]) begin
            d.div = q.wdata[HW_DIV_LSB +: 4];
            d.osc_run = q.wdata[HW_OSC_RUN_BIT];
            d.slow_dis = q.wdata[HW_SLOW_DIS_BIT];
          end
        end
        MODE_OFS: begin
          if (q.wstrb[0]) begin
            d.susp_req = q.wdata[MODE_SUSP_REQ_BIT];
            susp_fall = q.susp_req && !q.wdata[MODE_SUSP_REQ_BIT];
          end
        end
        STATUS_OFS: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end

    // read channel
    if (axi_req.arvalid && axi_rsp.arready) begin
      rd_val = reg_read(axi_req.araddr, q, rd_resp[1]);
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_resp;
    end else if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end

    // power state sequence
    case (q.pwr)
      ST_AWAKE: begin
        if (susp_fall) begin
          d.pwr = ST_SUSP_WAIT;
          d.tmr = TMR_W'(SUSP_CYCLES - 1);
        end
      end
      ST_SUSP_WAIT: begin
        if (wake_rise) begin
          d.pwr = ST_AWAKE;
        end else if (q.tmr == '0) begin
          d.pwr = ST_SUSPENDED;
        end else begin
          d.tmr = q.tmr - TMR_W'(1);
        end
      end
      ST_SUSPENDED: begin
        if (wake_rise) begin
          d.pwr = ST_WAKE_WAIT;
          d.tmr = TMR_W'(WAKE_CYCLES - 1);
        end
      end
      ST_WAKE_WAIT: begin
        if (q.tmr == '0) begin
          d.pwr = ST_AWAKE;
        end else begin
          d.tmr = q.tmr - TMR_W'(1);
        end
      end
      default: begin
        d.pwr = ST_AWAKE;
      end
    endcase

    // low-rate clock from the system clock
    if (q.lr_cnt >= 11'(LOW_HALF_CYC - 1)) begin
      d.lr_cnt = 11'h0;
      d.lr_clk = ~q.lr_clk;
    end else begin
      d.lr_cnt = q.lr_cnt + 11'h1;
    end

    // output clock select
    if (q.pwr == ST_SUSPENDED || q.pwr == ST_WAKE_WAIT) begin
      d.clk_out = q.slow_dis ? 1'b0 : q.lr_clk;
    end else begin
      d.clk_out = clk_div;
    end

    // internal reset returns control bits to defaults
    if (int_rst) begin
      d.div = DIV_RST;
      d.osc_run = OSC_RUN_RST;
      d.slow_dis = SLOW_DIS_RST;
      d.susp_req = 1'b0;
      d.pwr = ST_AWAKE;
      d.tmr = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
      q.por <= 1'b1;
      q.div <= DIV_RST;
      q.osc_run <= OSC_RUN_RST;
      q.slow_dis <= SLOW_DIS_RST;
      q.pwr <= ST_AWAKE;
    end else begin
      q <= d;
    end
  end

  // bus handshakes
  assign axi_rsp.awready = !q.aw_got && !q.bvalid;
  assign axi_rsp.wready = !q.w_got && !q.bvalid;
  assign axi_rsp.bvalid = q.bvalid;
  assign axi_rsp.bresp = q.bresp;
  assign axi_rsp.arready = !q.rvalid;
  assign axi_rsp.rvalid = q.rvalid;
  assign axi_rsp.rdata = q.rdata;
  assign axi_rsp.rresp = q.rresp;

  assign osc_enable = osc_on;
  assign pll_enable = osc_on;
  assign clock_output = q.clk_out;
  assign device_suspend_out = (q.pwr == ST_SUSPENDED) || (q.pwr == ST_WAKE_WAIT);
  assign int_reset = int_rst;
endmodule : cosp_ctrl
`default_nettype wire

/* core/cosp_pkg.sv */
`default_nettype none
package cosp_pkg;
  // timing base
  localparam int CLK_MHZ = 250;
  localparam int REF_MHZ = 6;
  localparam int PLL_MULT = 8;
  localparam int PLL_MHZ = REF_MHZ * PLL_MULT;
  localparam int SUSP_DELAY_US = 2000;
  localparam int SUSP_CYC = SUSP_DELAY_US * CLK_MHZ;
  localparam int WAKE_DELAY_NS = 500000;
  localparam int WAKE_CYC = WAKE_DELAY_NS * CLK_MHZ / 1000;
  localparam int POR_DIP_NS = 11000;
  localparam int POR_DIP_CYC = (POR_DIP_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_PULSE_NS = 600;
  localparam int POR_PULSE_CYC = (POR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOW_RATE_HZ = 100000;
  localparam int LOW_HALF_CYC = CLK_MHZ * 1000000 / (2 * LOW_RATE_HZ);
  localparam int REF_LOSS_CYC = 64;
  localparam int PLL_LOCK_EDGES = 16;
  // half-period tick rate of the pll clock as a phase increment
  localparam logic [31:0] NCO_INC = 32'((64'(2 * PLL_MHZ) << 32) / 64'(CLK_MHZ));
  localparam int TMR_W = 20;

  // register map
  localparam int AW = 12;
  localparam logic [AW-1:0] HW_CONFIG_OFS = 12'h000;
  localparam logic [AW-1:0] MODE_OFS = 12'h004;
  localparam logic [AW-1:0] STATUS_OFS = 12'h008;
  localparam int HW_DIV_LSB = 0;
  localparam int HW_OSC_RUN_BIT = 4;
  localparam int HW_SLOW_DIS_BIT = 5;
  localparam int MODE_SUSP_REQ_BIT = 0;
  localparam int ST_SUSPENDED_BIT = 0;
  localparam int ST_WAKE_WAIT_BIT = 1;
  localparam int ST_PLL_LOCK_BIT = 2;
  localparam int ST_LOW_RATE_BIT = 3;
  localparam int ST_SUSP_WAIT_BIT = 4;
  localparam int ST_OSC_ON_BIT = 5;
  localparam logic [3:0] DIV_RST = 4'h3;
  localparam logic OSC_RUN_RST = 1'b1;
  localparam logic SLOW_DIS_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } cosp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cosp_axi_rsp_t;

  typedef enum logic [1:0] {ST_AWAKE, ST_SUSP_WAIT, ST_SUSPENDED, ST_WAKE_WAIT} cosp_pwr_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [3:0] cnt;
    logic clk;
  } cosp_div_st_t;

  typedef struct packed {
    logic osc_s1, osc_s2, osc_s3;
    logic wake_s1, wake_s2, wake_s3;
    logic vmon_s1, vmon_s2;
    logic rstp_s1, rstp_s2;
    logic por;
    logic [11:0] low_cnt;
    logic [7:0] hold_cnt;
    logic [3:0] div;
    logic osc_run;
    logic slow_dis;
    logic susp_req;
    cosp_pwr_t pwr;
    logic [TMR_W-1:0] tmr;
    logic [4:0] lock_cnt;
    logic locked;
    logic [6:0] loss_cnt;
    logic [10:0] lr_cnt;
    logic lr_clk;
    logic clk_out;
    logic aw_got;
    logic [AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cosp_st_t;
endpackage : cosp_pkg
`default_nettype wire

/* tb/clock_out_suspend_por_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_out_suspend_por_ctrl_bench;
  import cosp_pkg::*;
  localparam int SUSP = 200;
  localparam int WAKE = 100;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wake = 1'b0;
  logic vmon = 1'b1;
  logic pin_n = 1'b1;
  logic ref_clk, osc_en, pll_en, cko, susp, irst;
  logic [2:0] mon;
  cosp_axi_req_t req = '0;
  cosp_axi_rsp_t rsp;
  logic [65:0] q[$];
  logic [65:0] e;
  logic [31:0] r;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 32'he007;
  int cyc = 0;
  int edges = 0;
  int n, t;
  assign mon = {cko, susp, irst};
  always #2 clk_sys = ~clk_sys;
  always @(posedge cko) edges++;
  cosp_ctrl #(.SUSP_CYCLES(SUSP), .WAKE_CYCLES(WAKE)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .axi_req(req),
    .axi_rsp(rsp), .osc_ref_in(ref_clk), .device_wake_in(wake), .vmon_ok(vmon), .reset_pin_n(pin_n),
    .osc_enable(osc_en), .pll_enable(pll_en), .clock_output(cko), .device_suspend_out(susp), .int_reset(irst));
  cosp_ref_model u_ref (.osc_enable(osc_en), .osc_ref_in(ref_clk));
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cy(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cy
  task automatic wait_lvl(input int k, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (mon[k] !== v && n < lim);
  endtask : wait_lvl
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] rs,
                     input logic [31:0] m);
    cosp_axi_rsp_t s;
    q.push_back({m, rs, d & m});
    @(posedge clk_sys);
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do begin
      @(negedge clk_sys);
      s = rsp;
      @(posedge clk_sys);
      if (s.awready) req.awvalid <= 1'b0;
      if (s.wready) req.wvalid <= 1'b0;
      if (s.bvalid) req.bready <= 1'b0;
      if (s.arready) req.arvalid <= 1'b0;
      if (s.rvalid) req.rready <= 1'b0;
    end while (!(s.bvalid || s.rvalid));
  endtask : bus
  // response checker
  always @(negedge clk_sys) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      e = q.pop_front();
      chk(rsp.bvalid ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata & e[65:34]}, e[33:0]);
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    cy(10);
    nrst <= 1'b1;
    wait_lvl(0, 1'b0, 400);
    chk(34'(n > 149 && n < 166), 34'h1);
    bus(1'b0, HW_CONFIG_OFS, 32'({SLOW_DIS_RST, OSC_RUN_RST, DIV_RST}), RESP_OKAY, '1);
    bus(1'b0, 12'h00c, 32'h0, RESP_SLVERR, '0);
    bus(1'b1, 12'h010, 32'h0, RESP_SLVERR, '0);
    bus(1'b1, HW_CONFIG_OFS, 32'h3, RESP_OKAY, '0);
    #1 chk(34'({osc_en, pll_en}), 34'h0);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      bus(1'b1, HW_CONFIG_OFS, {r[31:6], 6'h10 | 6'(i)}, RESP_OKAY, '0);
      bus(1'b0, HW_CONFIG_OFS, 32'h10 | 32'(i), RESP_OKAY, '1);
      cy(800);
      t = edges;
      cy(2500);
      t = edges - t - 480 / (i + 1);
      chk(34'(t > -4 && t < 4), 34'h1);
    end
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, HW_CONFIG_OFS, 32'h13 | 32'(s) << HW_SLOW_DIS_BIT, RESP_OKAY, '0);
      bus(1'b1, MODE_OFS, 32'h1, RESP_OKAY, '0);
      bus(1'b1, MODE_OFS, 32'h0, RESP_OKAY, '0);
      wait_lvl(1, 1'b1, 400);
      chk(34'(n > SUSP - 7 && n < SUSP + 7), 34'h1);
      chk(34'({osc_en, pll_en}), 34'h0);
      bus(1'b0, STATUS_OFS, 32'h1, RESP_OKAY, 32'h1);
      wait_lvl(2, s == 0, 4000);
      wait_lvl(2, s != 0, 4000);
      chk(34'(s ? cko === 1'b0 : n > 624 && n < 1876), 34'h1);
      cy(1);
      wake <= 1'b1;
      cy(4);
      wake <= 1'b0;
      wait_lvl(1, 1'b0, 400);
      chk(34'(n > WAKE - 10 && n < WAKE + 6), 34'h1);
      cy(800);
    end
    vmon <= 1'b0;
    cy(2000);
    vmon <= 1'b1;
    cy(10);
    #1 chk(34'(irst), 34'h0);
    cy(1);
    vmon <= 1'b0;
    cy(2800);
    #1 chk(34'(irst), 34'h1);
    cy(1);
    vmon <= 1'b1;
    wait_lvl(0, 1'b0, 400);
    chk(34'(n > 149 && n < 166), 34'h1);
    cy(1);
    pin_n <= 1'b0;
    cy(6);
    #1 chk(34'(irst), 34'h1);
    cy(1);
    pin_n <= 1'b1;
    wait_lvl(0, 1'b0, 20);
    chk(34'(irst), 34'h0);
    end_sim();
  end
endmodule : clock_out_suspend_por_ctrl_bench
`default_nettype wire

/* tb/cosp_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cosp_ctrl_monitor
  import cosp_pkg::*;
#(
  parameter int SUSP_CYCLES = SUSP_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  // clock
  input wire logic clk_sys,
  input wire logic nrst,
  // bus
  input wire cosp_axi_req_t axi_req,
  input wire cosp_axi_rsp_t axi_rsp,
  // pins
  input wire logic osc_ref_in,
  input wire logic device_wake_in,
  input wire logic vmon_ok,
  input wire logic reset_pin_n,
  // outputs
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic clock_output,
  input wire logic device_suspend_out,
  input wire logic int_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic lr, ck_q;
  // toggles seen in low-rate mode; the first two may be partial
  logic [1:0] tg_q;
  logic [11:0] dip_q, hp_q;
  logic [19:0] wk_q;
  assign lr = device_suspend_out && !osc_enable;
  always_ff @(posedge clk_sys) begin
    ck_q <= clock_output;
    dip_q <= vmon_ok ? 12'h0 : dip_q + 12'(dip_q < 12'd3000);
    wk_q <= (device_suspend_out && osc_enable) ? wk_q + 20'h1 : 20'h0;
    hp_q <= (lr && clock_output == ck_q) ? hp_q + 12'h1 : 12'h0;
    tg_q <= !lr ? 2'h0 : tg_q + 2'((clock_output != ck_q) && (tg_q != 2'h2));
  end
  a_susp_osc_off: assert property ($rose(device_suspend_out) |-> !osc_enable && !pll_enable)
    else $error("oscillator on in suspend");
  a_low_rate_half: assert property (lr && tg_q == 2'h2 && clock_output != ck_q |-> hp_q > 12'd623 && hp_q < 12'd1876)
    else $error("low rate clock off");
  a_wake_delay: assert property ($fell(device_suspend_out) |->
    wk_q + 20'd4 >= 20'(WAKE_CYCLES) && wk_q <= 20'(WAKE_CYCLES + 4)) else $error("wake delay wrong");
  a_reset_start: assert property (disable iff (1'b0) !nrst |=> int_reset)
    else $error("reset not held");
  a_por_hold: assert property ($fell(int_reset) |-> $past(vmon_ok, 150))
    else $error("reset released early");
  a_dip_reset: assert property (dip_q == 12'd2760 |-> int_reset)
    else $error("long dip ignored");
  a_dip_short: assert property (reset_pin_n [*5] ##0 $rose(int_reset) |-> dip_q > 12'd2747)
    else $error("short dip reset");
  a_pin_reset: assert property (!reset_pin_n [*4] |-> int_reset)
    else $error("pin reset ignored");
endmodule : cosp_ctrl_monitor
bind cosp_ctrl cosp_ctrl_monitor #(.SUSP_CYCLES(SUSP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp), .osc_ref_in(osc_ref_in),
  .device_wake_in(device_wake_in), .vmon_ok(vmon_ok), .reset_pin_n(reset_pin_n), .osc_enable(osc_enable),
  .pll_enable(pll_enable), .clock_output(clock_output), .device_suspend_out(device_suspend_out),
  .int_reset(int_reset));
`default_nettype wire

/* tb/cosp_ref_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cosp_ref_model (
  // control
  input wire logic osc_enable,
  // reference
  output logic osc_ref_in
);
  initial osc_ref_in = 1'b0;
  // 6 MHz, quiet while the oscillator is off
  always begin
    #83.3;
    osc_ref_in = osc_enable ? !osc_ref_in : 1'b0;
  end
endmodule : cosp_ref_model
`default_nettype wire
